// *** logic/host_port_if.sv ***
// carrier between the top and one host port monitor
interface host_port_if;
    logic                        active;
    logic                        ce;
    logic [1:0]                  line_level;
    logic                        fault_in;
    logic                        clr_line;
    logic                        clr_fault;
    logic                        xcvr_wr;
    logic [7:0]                  xcvr_wdata;
    logic                        psw_wr;
    logic                        psw_wdata;
    logic                        cmd_wr;
    logic [3:0]                  cmd;
    logic                        line_flag;
    logic                        fault_flag;
    logic                        fault_state;
    logic [1:0]                  line_q;
    logic [7:0]                  xcvr;
    logic                        psw;
    usb_attach_pkg::host_state_t hstate;

    modport ctl (output active, ce, line_level, fault_in, clr_line, clr_fault,
                 xcvr_wr, xcvr_wdata, psw_wr, psw_wdata, cmd_wr, cmd,
                 input line_flag, fault_flag, fault_state, line_q, xcvr, psw, hstate);
    modport mon (input active, ce, line_level, fault_in, clr_line, clr_fault,
                 xcvr_wr, xcvr_wdata, psw_wr, psw_wdata, cmd_wr, cmd,
                 output line_flag, fault_flag, fault_state, line_q, xcvr, psw, hstate);
endinterface

// *** logic/host_port_monitor.sv ***
// line change, power fault and transceiver/power settings of one host port
module host_port_monitor (
    input  wire logic clk_in,
    input  wire logic rst_in,
    host_port_if.mon  hp
);

    typedef struct packed {
        logic [1:0]                  line_prev;
        logic                        line_flag;
        logic                        fault_flag;
        logic                        fault_lvl;
        logic [7:0]                  xcvr;
        logic                        psw;
        usb_attach_pkg::host_state_t hstate;
    } mon_state_t;

    mon_state_t               st_q;
    mon_state_t               st_d;
    usb_attach_pkg::cmd_effect_t eff;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        eff  = usb_attach_pkg::cmd_effect(hp.cmd);
        if (hp.ce) begin
            // tracking runs on every enabled cycle, so sleep and active behave alike
            st_d.line_prev = hp.line_level;
            st_d.fault_lvl = hp.fault_in;
            if (hp.clr_line) begin
                st_d.line_flag = 1'b0;
            end
            if (hp.active && hp.line_level != st_q.line_prev) begin
                st_d.line_flag = 1'b1;
            end
            if (hp.clr_fault) begin
                st_d.fault_flag = 1'b0;
            end
            if (hp.active && hp.fault_in) begin
                st_d.fault_flag = 1'b1;
            end
            // settings survive a role change untouched
            if (hp.xcvr_wr) begin
                st_d.xcvr = hp.xcvr_wdata;
            end
            if (hp.psw_wr) begin
                st_d.psw = hp.psw_wdata;
            end
            // command wins over a same-cycle plain write
            if (hp.cmd_wr && eff.valid) begin
                st_d.xcvr   = eff.xcvr;
                st_d.psw    = eff.psw;
                st_d.hstate = eff.st;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '{usb_attach_pkg::LINE_RST, 1'b0, 1'b0, 1'b0,
                      usb_attach_pkg::XCVR_RST, usb_attach_pkg::PSW_RST,
                      usb_attach_pkg::HS_IDLE};
        end else begin
            st_q <= st_d;
        end
    end

    assign hp.line_flag   = st_q.line_flag;
    assign hp.fault_flag  = st_q.fault_flag;
    assign hp.fault_state = st_q.fault_lvl;
    assign hp.line_q      = st_q.line_prev;
    assign hp.xcvr        = st_q.xcvr;
    assign hp.psw         = st_q.psw;
    assign hp.hstate      = st_q.hstate;

endmodule // host_port_monitor

// *** logic/usb_attach_pkg.sv ***
// constants and types for port role selection and attach detection
//
// How it works
// - port 0 role: 1 host, 0 device
// - port 1 runs host functions only
// - only the selected mode's bits act
// - shared register mirrored at each port
// - detection runs in SLEEP and ACTIVE
// - device mode: bus power change sets flag
// - power change enable gates device summary
// - read-only bus power level bit
// - fault input sets fault flag, state bit
// - fault enable gates host summary
// - switch enable bit drives switch pin
// - line change sets flag, enable gates summary
// - two-bit line level reported
// - two-bit op select in transceiver control
// - detection settings kept into host mode
// - host command sets transceiver and power
package usb_attach_pkg;

    // ----------------------------------------
    // reset values and field positions
    // ----------------------------------------
    localparam logic       ROLE_RST   = 1'b0;
    localparam logic       PSW_RST    = 1'b0;
    localparam logic [7:0] XCVR_RST   = 8'h00;
    localparam logic [7:0] XCVR_DET   = 8'h93;
    localparam logic [1:0] LINE_RST   = 2'h0;
    localparam logic [7:0] SHARED_RST = 8'h00;
    localparam int         OPSEL_LSB  = 0;

    // ----------------------------------------
    // host state commands and their settings
    // ----------------------------------------
    localparam logic [3:0] HCMD_SUSPEND = 4'h1;
    localparam logic [3:0] HCMD_RESET   = 4'h2;
    localparam logic [3:0] HCMD_OPERATE = 4'h3;
    localparam logic [3:0] HCMD_IDLE    = 4'h4;
    localparam logic [7:0] XCVR_SUSPEND = XCVR_DET;
    localparam logic [7:0] XCVR_RESET   = 8'h50;
    localparam logic [7:0] XCVR_OPERATE = 8'h00;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_SUSPEND,
        HS_RESET,
        HS_OPERATE
    } host_state_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  xcvr;
        logic        psw;
        host_state_t st;
    } cmd_effect_t;

    function automatic cmd_effect_t cmd_effect(input logic [3:0] cmd);
        cmd_effect_t e;
        e = '{valid: 1'b1, xcvr: XCVR_DET, psw: 1'b0, st: HS_IDLE};
        case (cmd)
            HCMD_SUSPEND: e = '{1'b1, XCVR_SUSPEND, 1'b1, HS_SUSPEND};
            HCMD_RESET:   e = '{1'b1, XCVR_RESET, 1'b1, HS_RESET};
            HCMD_OPERATE: e = '{1'b1, XCVR_OPERATE, 1'b1, HS_OPERATE};
            HCMD_IDLE:    e = '{1'b1, XCVR_DET, 1'b0, HS_IDLE};
            default:      e.valid = 1'b0;
        endcase
        return e;
    endfunction

endpackage

// *** logic/usb_port_role_and_attach_detect.sv ***
// port role selection and port change detection for two usb ports
module usb_port_role_and_attach_detect (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             port0_role_select_in,
    input  wire logic             port0_sleep_in,
    input  wire logic             port0_bus_power_sense_in,
    input  wire logic             vbus_change_clear_in,
    input  wire logic             vbus_change_enable_in,
    input  wire logic [1:0]       shared_write_in,
    input  wire logic [7:0]       shared_wdata_in,
    input  wire logic [1:0][1:0]  line_level_in,
    input  wire logic [1:0]       power_fault_input_in,
    input  wire logic [1:0]       line_change_clear_in,
    input  wire logic [1:0]       line_change_enable_in,
    input  wire logic [1:0]       power_fault_clear_in,
    input  wire logic [1:0]       power_fault_enable_in,
    input  wire logic [1:0]       xcvr_write_in,
    input  wire logic [1:0][7:0]  xcvr_wdata_in,
    input  wire logic [1:0]       psw_write_in,
    input  wire logic [1:0]       psw_wdata_in,
    input  wire logic [1:0]       host_cmd_write_in,
    input  wire logic [1:0][3:0]  host_state_command_in,
    output logic                  port0_role_out,
    output logic                  vbus_change_flag_out,
    output logic                  device_vbus_level_out,
    output logic                  device_event_summary_out,
    output logic [1:0]            line_change_flag_out,
    output logic [1:0]            power_fault_flag_out,
    output logic [1:0]            host_power_fault_state_out,
    output logic [1:0][1:0]       line_level_out,
    output logic [1:0][7:0]       transceiver_control_out,
    output logic [1:0][1:0]       xcvr_op_select_out,
    output logic [1:0]            power_switch_output_out,
    output logic [1:0][1:0]       host_state_out,
    output logic [1:0]            host_event_summary_out,
    output logic [1:0][1:0]       main_event_status_out,
    output logic [1:0][7:0]       shared_port_out
);

    typedef struct packed {
        logic       role;
        logic       vbus_prev;
        logic       vbus_flag;
        logic [7:0] shared;
    } top_state_t;

    top_state_t st_q;
    top_state_t st_d;
    logic [1:0] active;
    usb_attach_pkg::cmd_effect_t cmd_eff [2];

    host_port_if hp [2] ();

    // ----------------------------------------
    // role, bus power detection, shared register
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        if (ce_in) begin
            // a role flip outside sleep would tear a live session
            if (port0_sleep_in) begin
                st_d.role = port0_role_select_in;
            end
            st_d.vbus_prev = port0_bus_power_sense_in;
            if (vbus_change_clear_in) begin
                st_d.vbus_flag = 1'b0;
            end
            if (!st_q.role && port0_bus_power_sense_in != st_q.vbus_prev) begin
                st_d.vbus_flag = 1'b1;
            end
            // one register, written from either port, read at both
            if (shared_write_in[0]) begin
                st_d.shared = shared_wdata_in;
            end else if (shared_write_in[1]) begin
                st_d.shared = shared_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= '{usb_attach_pkg::ROLE_RST, 1'b0, 1'b0,
                      usb_attach_pkg::SHARED_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign active = {1'b1, st_q.role};

    // ----------------------------------------
    // device side outputs
    // ----------------------------------------
    assign port0_role_out        = st_q.role;
    assign vbus_change_flag_out  = st_q.vbus_flag & ~st_q.role;
    assign device_vbus_level_out = st_q.vbus_prev & ~st_q.role;
    assign device_event_summary_out =
        vbus_change_flag_out & vbus_change_enable_in;

    // ----------------------------------------
    // host ports
    // ----------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_host
        assign hp[i].active     = active[i];
        assign hp[i].ce         = ce_in;
        assign hp[i].line_level = line_level_in[i];
        assign hp[i].fault_in   = power_fault_input_in[i];
        assign hp[i].clr_line   = line_change_clear_in[i];
        assign hp[i].clr_fault  = power_fault_clear_in[i];
        // host settings accept writes only while host mode is on
        assign hp[i].xcvr_wr    = xcvr_write_in[i] & active[i];
        assign hp[i].xcvr_wdata = xcvr_wdata_in[i];
        assign hp[i].psw_wr     = psw_write_in[i] & active[i];
        assign hp[i].psw_wdata  = psw_wdata_in[i];
        assign hp[i].cmd_wr     = host_cmd_write_in[i] & active[i];
        assign hp[i].cmd        = host_state_command_in[i];
        assign cmd_eff[i] = usb_attach_pkg::cmd_effect(hp[i].cmd);

        host_port_monitor u_mon (
            .clk_in (clk_in),
            .rst_in (rst_in),
            .hp     (hp[i])
        );

        assign line_change_flag_out[i]       = hp[i].line_flag & active[i];
        assign power_fault_flag_out[i]       = hp[i].fault_flag & active[i];
        assign host_power_fault_state_out[i] = hp[i].fault_state & active[i];
        assign line_level_out[i]          = active[i] ? hp[i].line_q : 2'h0;
        assign transceiver_control_out[i] = active[i] ? hp[i].xcvr : 8'h00;
        assign xcvr_op_select_out[i] =
            transceiver_control_out[i][usb_attach_pkg::OPSEL_LSB +: 2];
        assign power_switch_output_out[i] = hp[i].psw & active[i];
        assign host_state_out[i]  = active[i] ? hp[i].hstate : 2'h0;
        assign host_event_summary_out[i] =
            (line_change_flag_out[i] & line_change_enable_in[i]) |
            (power_fault_flag_out[i] & power_fault_enable_in[i]);
        assign shared_port_out[i] = st_q.shared;
    end

    assign main_event_status_out[0] = {host_event_summary_out[0],
                                       device_event_summary_out};
    assign main_event_status_out[1] = {host_event_summary_out[1], 1'b0};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence seq_vbus_edge;
        ce_in && !st_q.role && port0_bus_power_sense_in != st_q.vbus_prev;
    endsequence

    sequence seq_cmd_write(int p);
        ce_in && host_cmd_write_in[p] && active[p] &&
        cmd_eff[p].valid;
    endsequence

    chk_role_sleep_hold: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !port0_sleep_in |=> $stable(port0_role_out))
        else $error("role changed outside sleep");

    chk_role_takes_select: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && port0_sleep_in |=> port0_role_out == $past(port0_role_select_in))
        else $error("role not taken in sleep");

    chk_vbus_edge_flag: assert property (
        @(posedge clk_in) disable iff (rst_in)
        seq_vbus_edge ##1 !st_q.role |-> vbus_change_flag_out)
        else $error("bus power change not flagged");

    chk_vbus_flag_kept: assert property (
        @(posedge clk_in) disable iff (rst_in)
        vbus_change_flag_out && !vbus_change_clear_in && !port0_sleep_in
        |=> vbus_change_flag_out || !ce_in)
        else $error("bus power flag lost");

    chk_dev_summary_gate: assert property (
        @(posedge clk_in) disable iff (rst_in)
        device_event_summary_out |-> vbus_change_enable_in && st_q.vbus_flag)
        else $error("device summary without enabled flag");

    chk_vbus_level_read: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && !st_q.role && !port0_sleep_in
        |=> device_vbus_level_out == $past(port0_bus_power_sense_in))
        else $error("bus power level wrong");

    chk_device_masked: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port0_role_out |-> !vbus_change_flag_out && !device_event_summary_out)
        else $error("device bits seen in host mode");

    chk_host_masked: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !port0_role_out |-> power_switch_output_out[0] == 1'b0 &&
        line_change_flag_out[0] == 1'b0 && transceiver_control_out[0] == 8'h00)
        else $error("host bits seen in device mode");

    chk_shared_mirror: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && |shared_write_in
        |=> shared_port_out[1] == $past(shared_wdata_in) &&
        shared_port_out[0] == shared_port_out[1])
        else $error("shared register not mirrored");

    chk_vbus_flag_clear: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && vbus_change_clear_in && port0_bus_power_sense_in == st_q.vbus_prev
        |=> !st_q.vbus_flag)
        else $error("bus power flag kept");

    chk_dev_summary_set: assert property (
        @(posedge clk_in) disable iff (rst_in)
        vbus_change_flag_out && vbus_change_enable_in
        |-> device_event_summary_out)
        else $error("device summary missing");

    for (genvar p = 0; p < 2; p++) begin : g_chk
        chk_fault_sets_flag: assert property (
            @(posedge clk_in) disable iff (rst_in)
            ce_in && active[p] && power_fault_input_in[p] ##1 active[p]
            |-> power_fault_flag_out[p] && host_power_fault_state_out[p])
            else $error("fault not flagged");

        chk_fault_summary: assert property (
            @(posedge clk_in) disable iff (rst_in)
            power_fault_flag_out[p] && power_fault_enable_in[p]
            |-> host_event_summary_out[p])
            else $error("enabled fault missing from summary");

        chk_line_change: assert property (
            @(posedge clk_in) disable iff (rst_in)
            ce_in && active[p] && line_level_in[p] != hp[p].line_q ##1 active[p]
            |-> line_change_flag_out[p])
            else $error("line change not flagged");

        chk_summary_drop: assert property (
            @(posedge clk_in) disable iff (rst_in)
            !line_change_enable_in[p] && !power_fault_enable_in[p]
            |-> !host_event_summary_out[p])
            else $error("summary without enabled source");

        chk_psw_write: assert property (
            @(posedge clk_in) disable iff (rst_in)
            ce_in && psw_write_in[p] && active[p] && !host_cmd_write_in[p]
            ##1 active[p] |-> power_switch_output_out[p] == $past(psw_wdata_in[p]))
            else $error("power switch pin not following write");

        chk_cmd_apply: assert property (
            @(posedge clk_in) disable iff (rst_in)
            seq_cmd_write(p) ##1 active[p] |-> transceiver_control_out[p] ==
            $past(cmd_eff[p].xcvr))
            else $error("host command did not set transceiver");

        chk_cmd_state: assert property (
            @(posedge clk_in) disable iff (rst_in)
            seq_cmd_write(p) ##1 active[p] |-> host_state_out[p] == $past(cmd_eff[p].st))
            else $error("host command not applied");

        chk_xcvr_write: assert property (
            @(posedge clk_in) disable iff (rst_in)
            ce_in && xcvr_write_in[p] && active[p] && !host_cmd_write_in[p]
            ##1 active[p] |-> transceiver_control_out[p] == $past(xcvr_wdata_in[p]))
            else $error("transceiver write lost");

        chk_line_clear: assert property (
            @(posedge clk_in) disable iff (rst_in)
            ce_in && line_change_clear_in[p] && line_level_in[p] == hp[p].line_q
            |=> !hp[p].line_flag)
            else $error("line flag kept");

        chk_fault_clear: assert property (
            @(posedge clk_in) disable iff (rst_in)
            ce_in && power_fault_clear_in[p] && !power_fault_input_in[p]
            |=> !hp[p].fault_flag)
            else $error("fault flag kept");

        chk_line_level: assert property (
            @(posedge clk_in) disable iff (rst_in)
            ce_in && active[p] ##1 active[p]
            |-> line_level_out[p] == $past(line_level_in[p]))
            else $error("line level wrong");

        chk_line_summary: assert property (
            @(posedge clk_in) disable iff (rst_in)
            line_change_flag_out[p] && line_change_enable_in[p]
            |-> host_event_summary_out[p])
            else $error("line summary missing");

        chk_xcvr_kept: assert property (
            @(posedge clk_in) disable iff (rst_in)
            !xcvr_write_in[p] && !host_cmd_write_in[p] |=> $stable(hp[p].xcvr))
            else $error("transceiver setting lost");
    end

endmodule // usb_port_role_and_attach_detect

// *** verif/usb_far_side_model.sv ***
// far side of both ports: attached device or upstream host, and the power switches
module usb_far_side_model (
    input  wire logic            supply_in,
    input  wire logic [1:0][1:0] attach_in,
    input  wire logic [1:0]      overload_in,
    input  wire logic [1:0]      psw_in,
    output logic                 sense_out,
    output logic [1:0][1:0]      line_out,
    output logic [1:0]           fault_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // upstream host drives bus power into port 0 sense
    assign sense_out = supply_in;
    // host pull-downs hold a detached cable at se0, so 00 means nothing attached
    assign line_out  = attach_in;
    // switch can only trip while the port has it turned on
    assign fault_out = overload_in & psw_in;
endmodule // usb_far_side_model

// *** verif/usb_port_role_and_attach_detect_test.sv ***
// self-checking bench for port role selection and attach detection
module usb_port_role_and_attach_detect_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // stimulus, outputs and reference state
    // ----------------------------------------
    logic clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, sel = 1'b0, slp = 1'b1;
    logic vclr = 1'b0, ven = 1'b0, sup = 1'b0, sense;
    logic [1:0] shw = '0, lclr = '0, len = '0, fclr = '0, fen = '0, ovl = '0;
    logic [1:0] xw = '0, pw = '0, pd = '0, cw = '0, flt;
    logic [1:0][1:0] attach = '0, lvl;
    logic [1:0][7:0] xd = '0;
    logic [1:0][3:0] cmd = '0;
    logic [7:0] shd = '0;
    logic role_o, vflag_o, vlev_o, dsum_o;
    logic [1:0] lflag_o, fflag_o, fst_o, psw_o, hsum_o;
    logic [1:0][1:0] line_o, ops_o, hst_o, main_o;
    logic [1:0][7:0] xcvr_o, shp_o;
    logic m_role, m_vf, m_vl, m_vh;
    logic [1:0] m_lf, m_ff, m_fs, m_p;
    logic [1:0][1:0] m_lh, m_h;
    logic [1:0][7:0] m_x;
    logic [7:0] m_sh;
    logic [15:0] r = 16'h456E;
    int failures = 0, tests_run = 0;

    always #5 clk_in = ~clk_in;

    usb_far_side_model i_far (.supply_in(sup), .attach_in(attach), .overload_in(ovl),
        .psw_in(psw_o), .sense_out(sense), .line_out(lvl), .fault_out(flt));

    usb_port_role_and_attach_detect i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .port0_role_select_in(sel), .port0_sleep_in(slp), .port0_bus_power_sense_in(sense),
        .vbus_change_clear_in(vclr), .vbus_change_enable_in(ven), .shared_write_in(shw),
        .shared_wdata_in(shd), .line_level_in(lvl), .power_fault_input_in(flt),
        .line_change_clear_in(lclr), .line_change_enable_in(len),
        .power_fault_clear_in(fclr), .power_fault_enable_in(fen), .xcvr_write_in(xw),
        .xcvr_wdata_in(xd), .psw_write_in(pw), .psw_wdata_in(pd), .host_cmd_write_in(cw),
        .host_state_command_in(cmd), .port0_role_out(role_o), .vbus_change_flag_out(vflag_o),
        .device_vbus_level_out(vlev_o), .device_event_summary_out(dsum_o),
        .line_change_flag_out(lflag_o), .power_fault_flag_out(fflag_o),
        .host_power_fault_state_out(fst_o), .line_level_out(line_o),
        .transceiver_control_out(xcvr_o), .xcvr_op_select_out(ops_o),
        .power_switch_output_out(psw_o), .host_state_out(hst_o),
        .host_event_summary_out(hsum_o), .main_event_status_out(main_o),
        .shared_port_out(shp_o));

    // ----------------------------------------
    // reference model, advanced on the same edges as the design
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (rst_in) begin
            {m_role, m_vf, m_vl, m_vh, m_lf, m_ff, m_fs, m_p, m_lh, m_h, m_x, m_sh} <= '0;
        end else if (ce_in) begin
            if (slp) m_role <= sel;
            m_vh <= sense;
            m_vl <= sense;
            m_vf <= (!m_role && sense != m_vh) || (m_vf && !vclr);
            if (shw[0]) m_sh <= shd;
            else if (shw[1]) m_sh <= shd;
            for (int p = 0; p < 2; p++) begin
                logic a;
                a = (p == 1) || m_role;
                m_lh[p] <= lvl[p];
                m_fs[p] <= flt[p];
                m_lf[p] <= (a && lvl[p] != m_lh[p]) || (m_lf[p] && !lclr[p]);
                m_ff[p] <= (a && flt[p]) || (m_ff[p] && !fclr[p]);
                if (a && cw[p] && cmd[p] inside {[4'h1:4'h4]}) begin
                    m_x[p] <= cmd[p] == 4'h2 ? 8'h50 : cmd[p] == 4'h3 ? 8'h00 : 8'h93;
                    m_p[p] <= cmd[p] != 4'h4;
                    m_h[p] <= cmd[p][1:0];
                end else if (a) begin
                    if (xw[p]) m_x[p] <= xd[p];
                    if (pw[p]) m_p[p] <= pd[p];
                end
            end
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic compare_all();
        logic [1:0] a, hs;
        logic [1:0][7:0] mx;
        logic [1:0][1:0] ml, mh;
        logic ds;
        a = {1'b1, m_role};
        ds = !m_role & m_vf & ven;
        for (int p = 0; p < 2; p++) begin
            mx[p] = a[p] ? m_x[p] : 8'h00;
            ml[p] = a[p] ? m_lh[p] : 2'h0;
            mh[p] = a[p] ? m_h[p] : 2'h0;
            hs[p] = a[p] & (m_lf[p] & len[p] | m_ff[p] & fen[p]);
        end
        chk("role", 32'(m_role), 32'(role_o));
        chk("dev status", 32'({m_vf, m_vl} & {2{!m_role}}), 32'({vflag_o, vlev_o}));
        chk("dev summary", 32'(ds), 32'(dsum_o));
        chk("host flags", 32'({m_lf & a, m_ff & a, m_fs & a}),
            32'({lflag_o, fflag_o, fst_o}));
        chk("line level", 32'(ml), 32'(line_o));
        chk("xcvr", 32'(mx), 32'(xcvr_o));
        chk("op select", 32'({mx[1][1:0], mx[0][1:0]}), 32'(ops_o));
        chk("switch pin", 32'(m_p & a), 32'(psw_o));
        chk("host state", 32'(mh), 32'(hst_o));
        chk("host summary", 32'(hs), 32'(hsum_o));
        chk("main status", 32'({hs[1], 1'b0, hs[0], ds}), 32'(main_o));
        chk("shared", 32'({m_sh, m_sh}), 32'(shp_o));
    endtask

    always @(posedge clk_in) begin
        #2;
        compare_all();
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // random drive; port 0 lines stay quiet in device mode
    task automatic rnd(input int n, input logic h);
        logic [15:0] q;
        repeat (n) begin
            repeat (16) r = lfsr(r);
            q = r;
            repeat (16) r = lfsr(r);
            attach = {r[1:0], h ? r[3:2] : 2'h0};
            ovl = {r[4], h & r[5]};
            lclr = {r[6], h & r[7]};
            fclr = {r[8], h & r[9]};
            len = r[11:10];
            fen = r[13:12];
            ce_in = r[14] | r[15];
            xw = q[1:0] & q[3:2];
            xd = q;
            pw = q[5:4] & q[7:6];
            pd = q[9:8];
            cw = q[11:10] & q[13:12];
            cmd = {q[7:4], q[3:0]};
            shw = q[15:14];
            shd = q[7:0];
            slp = r[3] ^ q[3];
            sel = h;
            sup = h ? sup : q[12];
            vclr = q[13] & q[14];
            ven = r[9] ^ q[1];
            step();
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        step(8);
        rst_in = 1'b0;
        vclr = 1'b1; ven = 1'b1; step(); vclr = 1'b0;
        sup = 1'b1; step(3);
        vclr = 1'b1; ven = 1'b0; step(); vclr = 1'b0; step(2);
        slp = 1'b0; sel = 1'b1; step(3);
        slp = 1'b1; step(); slp = 1'b0; step();
        lclr = 2'h3; fclr = 2'h3; step(); lclr = 2'h0; fclr = 2'h0;
        len = 2'h3; fen = 2'h3; xw = 2'h3; xd = {8'h93, 8'h93}; step(); xw = 2'h0;
        pw = 2'h3; pd = 2'h3; step(); pw = 2'h0;
        attach = {2'h2, 2'h1}; step(3);
        lclr = 2'h3; len = 2'h0; step(); lclr = 2'h0;
        ovl = 2'h1; step(2); pw = 2'h1; pd = 2'h0; step(); pw = 2'h0;
        ovl = 2'h0; fclr = 2'h3; step(); fclr = 2'h0;
        for (int c = 1; c < 7; c++) begin
            cw = 2'h3; cmd = {4'(c), 4'(c)}; step();
        end
        cw = 2'h3; cmd = {4'h3, 4'h2}; xw = 2'h3; pw = 2'h3; pd = 2'h0; step();
        cw = 2'h0; xw = 2'h0; pw = 2'h0; ce_in = 1'b0; attach = '0; step(4);
        ce_in = 1'b1; step(2);
        rnd(600, 1'b1);
        {attach, ovl, lclr, fclr, xw, pw, cw, shw, sel, slp, vclr} = '0;
        ce_in = 1'b1; step(2);
        rst_in = 1'b1; step(2); rst_in = 1'b0; step(2);
        rnd(600, 1'b0);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        wrap_up();
    end
endmodule // usb_port_role_and_attach_detect_test
